// ### serial_print_pkg.sv
// Constants and carrier types for the printer serial port
`default_nettype none
package serial_print_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned BAUD_HI = 38400;
  localparam int unsigned BAUD_MID = 19200;
  localparam int unsigned BAUD_LO = 9600;
  // Bit periods in clock cycles, rounded down
  localparam int unsigned DIV_HI = CLK_HZ / BAUD_HI;
  localparam int unsigned DIV_MID = CLK_HZ / BAUD_MID;
  localparam int unsigned DIV_LO = CLK_HZ / BAUD_LO;
  localparam int unsigned DIV_W = 13;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;
  localparam logic [1:0] RATE_RESET = 2'h0;
  localparam logic [DIV_W-1:0] DIV_RESET = 13'h0000;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;

  typedef enum logic [1:0] {
    RATE_38400 = 2'h0,
    RATE_19200 = 2'h1,
    RATE_9600 = 2'h2
  } rate_type;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } char_type;
endpackage : serial_print_pkg
`default_nettype wire

// ### char_buffer.sv
// Two-entry valid/ready buffer carrying characters to the transmitter
`timescale 1ns/100ps
`default_nettype none
module char_buffer (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire serial_print_pkg::char_type in_data, // Incoming character
  input wire logic in_valid, // Incoming valid
  output logic in_ready, // Room available
  output serial_print_pkg::char_type out_data, // Oldest character
  output logic out_valid, // Buffer not empty
  input wire logic out_ready // Drain side takes a word
);
  serial_print_pkg::char_type mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  wire push = in_valid && in_ready && ce;
  wire pop = out_valid && out_ready && ce;

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];

  // Storage writes need no reset, only pointers and count do
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : char_buffer
`default_nettype wire

// ### printer_serial_port.sv
// Printer serial port: record source, baud detection and 8N1 transmitter
// Overview of operation
// - Eight data bits, one stop, no parity
// - No flow control; transmit never waits
// - Autodetect 38400, 19200 or 9600 baud
// - Deliver stored records to printer as characters
// - Print-all sends every memory record in turn
// - Print key sends the displayed force value
`timescale 1ns/100ps
`default_nettype none
module printer_serial_port #(
  parameter int unsigned ADDR_W = 10, // Record memory address width
  parameter int unsigned REC_BYTES = 8 // Characters per record
) (
  input wire logic clk, // System clock, 40 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic rx_pin, // Serial receive pin from printer
  output logic tx_pin, // Serial transmit pin to printer
  input wire logic print_all, // Pulse: print every stored record
  input wire logic print_key, // Pulse: save/print key pressed
  input wire logic key_is_print, // Key configured for printing
  input wire logic [ADDR_W-1:0] rec_count, // Records held in memory
  output logic [ADDR_W-1:0] mem_addr, // Record memory address
  input wire logic [8*REC_BYTES-1:0] mem_data, // Record read data, next cycle
  input wire logic [8*REC_BYTES-1:0] live_value, // Displayed force characters
  output logic busy, // Print job in progress
  output logic [1:0] rate // Detected rate code
);
  // J_WAIT lets the record address settle for a full cycle before the fetch
  typedef enum logic [4:0] {
    J_IDLE = 5'h01,
    J_WAIT = 5'h02,
    J_FETCH = 5'h04,
    J_SEND = 5'h08,
    J_NEXT = 5'h10
  } job_type;

  // Receive pin synchroniser; the second stage and its one-cycle delay rx_prev_reg are used
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_prev_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else if (ce) begin
      rx_s1_reg <= rx_pin;
      rx_s2_reg <= rx_s1_reg;
      rx_prev_reg <= rx_s2_reg;
    end
  end

  // Baud detection: width of shortest low pulse on the line picks the rate
  logic [15:0] low_cnt_reg;
  logic [1:0] rate_reg;
  logic seen_fast_reg; // Set by the first valid pulse
  wire rx_rise = rx_s2_reg && !rx_prev_reg;
  // Rate thresholds sit midway between neighbouring bit times; thr_min is half the fastest bit time
  wire [15:0] thr_hi = 16'((serial_print_pkg::DIV_HI + serial_print_pkg::DIV_MID) / 2);
  wire [15:0] thr_mid = 16'((serial_print_pkg::DIV_MID + serial_print_pkg::DIV_LO) / 2);
  wire [15:0] thr_min = 16'(serial_print_pkg::DIV_HI / 2);
  wire pulse_ok = rx_rise && (low_cnt_reg > thr_min);
  wire [1:0] rate_seen = (low_cnt_reg < thr_hi) ? serial_print_pkg::RATE_38400 :
                         (low_cnt_reg < thr_mid) ? serial_print_pkg::RATE_19200 :
                         serial_print_pkg::RATE_9600;
  // After the first valid pulse only faster rates are adopted, so long runs of zeros never slow it down
  wire rate_faster = pulse_ok && (rate_seen < rate_reg);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_reg <= 16'h0000;
      rate_reg <= serial_print_pkg::RATE_RESET;
    end else if (ce) begin
      if (rx_s2_reg) low_cnt_reg <= 16'h0000;
      else if (low_cnt_reg != 16'hFFFF) low_cnt_reg <= low_cnt_reg + 16'h0001;
      if (rate_faster || (pulse_ok && rate_reg == serial_print_pkg::RATE_38400
          && rate_seen != serial_print_pkg::RATE_38400 && !seen_fast_reg))
        rate_reg <= rate_seen;
    end
  end
  // Once any valid pulse is seen the rate only climbs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) seen_fast_reg <= 1'b0;
    else if (ce && pulse_ok) seen_fast_reg <= 1'b1;
  end
  // Rate code goes straight out; it changes only on a qualified pulse
  assign rate = rate_reg;

  // Bit time in clock cycles for the rate in force
  wire [serial_print_pkg::DIV_W-1:0] bit_div =
    (rate_reg == serial_print_pkg::RATE_38400) ? serial_print_pkg::DIV_W'(serial_print_pkg::DIV_HI) :
    (rate_reg == serial_print_pkg::RATE_19200) ? serial_print_pkg::DIV_W'(serial_print_pkg::DIV_MID) :
    serial_print_pkg::DIV_W'(serial_print_pkg::DIV_LO);

  // Job sequencer: walks records or takes the live value
  job_type job_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [8*REC_BYTES-1:0] rec_reg;
  logic [$clog2(REC_BYTES+1)-1:0] idx_reg;
  logic from_mem_reg;
  serial_print_pkg::char_type push_char;
  logic push_ready;
  // Handshake into the buffer is combinational; data comes from rec_reg
  wire push_valid = (job_reg == J_SEND);
  wire rec_done = push_valid && push_ready && (idx_reg == REC_BYTES - 1);
  // rec_count is read live, so it must hold steady while a dump runs
  wire more_recs = from_mem_reg && (addr_reg + 1'b1 < rec_count);
  assign push_char.data = rec_reg[8*REC_BYTES-1 -: 8];
  assign push_char.last = (idx_reg == REC_BYTES - 1);
  assign mem_addr = addr_reg;
  assign busy = (job_reg != J_IDLE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      job_reg <= J_IDLE;
      addr_reg <= '0;
      rec_reg <= '0;
      idx_reg <= '0;
      from_mem_reg <= 1'b0;
    end else if (ce) begin
      case (job_reg)
        J_IDLE: begin
          addr_reg <= '0;
          idx_reg <= '0;
          // A memory dump outranks the key when both arrive together
          if (print_all && rec_count != '0) begin
            from_mem_reg <= 1'b1;
            job_reg <= J_WAIT;
          end else if (print_key && key_is_print) begin
            from_mem_reg <= 1'b0;
            rec_reg <= live_value;
            job_reg <= J_SEND;
          end
        end
        // Memory latches the settled address here; its data is valid next
        J_WAIT: begin
          job_reg <= J_FETCH;
        end
        J_FETCH: begin
          rec_reg <= mem_data;
          idx_reg <= '0;
          job_reg <= J_SEND;
        end
        // One character per accepted push, most significant byte first
        J_SEND: begin
          if (push_valid && push_ready) begin
            rec_reg <= rec_reg << 8; // Next byte to the top
            idx_reg <= idx_reg + 1'b1;
            if (rec_done) job_reg <= J_NEXT;
          end
        end
        // Step to the next record or go home
        J_NEXT: begin
          if (more_recs) begin
            addr_reg <= addr_reg + 1'b1;
            job_reg <= J_WAIT;
          end else begin
            job_reg <= J_IDLE;
          end
        end
        default: job_reg <= J_IDLE;
      endcase
    end
  end

  // Two-entry buffer absorbs transmitter stalls
  serial_print_pkg::char_type tx_char;
  logic tx_valid;
  logic tx_take;
  char_buffer u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .in_data(push_char),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(tx_char),
    .out_valid(tx_valid),
    .out_ready(tx_take)
  );

  // Transmitter: 10-bit frame, start low, LSB first, one stop, no parity
  logic [9:0] shift_reg;
  logic [3:0] bits_left_reg;
  logic [serial_print_pkg::DIV_W-1:0] div_cnt_reg;
  // Bit time is frozen per frame, so a rate pulse mid-character cannot tear it
  logic [serial_print_pkg::DIV_W-1:0] frame_div_reg;
  wire tx_idle = (bits_left_reg == 4'h0);
  wire bit_end = (div_cnt_reg == frame_div_reg - 1'b1);
  // No flow-control input exists, so the frame starts as soon as a word waits
  assign tx_take = tx_idle;
  // Start, data and stop bits of one character
  localparam logic [3:0] FRAME_BITS = 4'(1 + serial_print_pkg::DATA_BITS +
                                         serial_print_pkg::STOP_BITS);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= 10'h3FF;
      bits_left_reg <= 4'h0;
      div_cnt_reg <= serial_print_pkg::DIV_RESET;
      frame_div_reg <= serial_print_pkg::DIV_RESET;
    end else if (ce) begin
      if (tx_idle) begin
        div_cnt_reg <= serial_print_pkg::DIV_RESET;
        if (tx_valid) begin
          shift_reg <= {1'b1, tx_char.data, 1'b0};
          bits_left_reg <= FRAME_BITS;
          frame_div_reg <= bit_div;
        end
      end else if (bit_end) begin
        // Next bit onto the line
        div_cnt_reg <= serial_print_pkg::DIV_RESET;
        shift_reg <= {1'b1, shift_reg[9:1]};
        bits_left_reg <= bits_left_reg - 4'h1;
      end else begin
        // Count cycles within the bit
        div_cnt_reg <= div_cnt_reg + 1'b1;
      end
    end
  end
  // Line forced to mark between frames
  assign tx_pin = tx_idle ? 1'b1 : shift_reg[0];
endmodule : printer_serial_port
`default_nettype wire

// ### serial_port_checker.sv
// Assertion checker for the printer serial port
`timescale 1ns/100ps
`default_nettype none
module serial_port_checker #(
  parameter int unsigned ADDR_W = 10
) (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic rx_pin, // Line from printer
  input wire logic tx_pin, // Line to printer
  input wire logic print_all, // Print-all pulse
  input wire logic print_key, // Key pulse
  input wire logic key_is_print, // Key prints
  input wire logic [ADDR_W-1:0] rec_count, // Stored records
  input wire logic busy, // Job running
  input wire logic [1:0] rate // Rate code
);
  logic [15:0] tx_lo_reg;
  logic [15:0] rx_lo_reg;
  logic [15:0] rx_hi_reg;
  logic [15:0] div;
  logic take;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Bit time of the rate in force; a rate change mid-frame would upset the run check
  assign div = (rate == 2'h0) ? 16'(serial_print_pkg::DIV_HI) :
               (rate == 2'h1) ? 16'(serial_print_pkg::DIV_MID) : 16'(serial_print_pkg::DIV_LO);
  assign take = ce && !busy;
  // Run lengths of tx low, rx low and rx high; the high run saturates so idle never wraps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_lo_reg <= 16'h0000;
      rx_lo_reg <= 16'h0000;
      rx_hi_reg <= 16'h0000;
    end else begin
      tx_lo_reg <= tx_pin ? 16'h0000 : tx_lo_reg + 16'h0001;
      rx_lo_reg <= rx_pin ? 16'h0000 : rx_lo_reg + 16'h0001;
      rx_hi_reg <= !rx_pin ? 16'h0000 : rx_hi_reg + {15'h0000, rx_hi_reg != 16'hFFFF};
    end
  end
  sequence key_take_s;
    take && print_key && key_is_print;
  endsequence
  sequence all_take_s;
    take && print_all && rec_count != '0;
  endsequence
  // Start plus zeros: whole bit times, never more than nine before the stop bit
  frame_bits_a:
    assert property ($rose(tx_pin) |-> tx_lo_reg != 16'h0000 && tx_lo_reg % div == 16'h0000
      && 32'(tx_lo_reg) <= 9 * 32'(div)) else $error("tx low run not whole bits");
  key_busy_a:
    assert property (key_take_s |=> busy) else $error("print key not taken");
  all_busy_a:
    assert property (all_take_s |=> busy) else $error("print all not taken");
  key_store_a:
    assert property (take && print_key && !key_is_print && !print_all |=> !busy)
      else $error("store key started a print");
  empty_all_a:
    assert property (take && print_all && rec_count == '0 && !print_key |=> !busy)
      else $error("empty memory started a print");
  rate_cause_a:
    assert property ($changed(rate) |-> rx_hi_reg < 16'h0008) else $error("rate moved without pulse");
  rate_code_a:
    assert property (rate != 2'h3) else $error("rate code unused value");
  rate_fast_a:
    assert property ($rose(rx_pin) && rx_lo_reg > 16'h0258 && rx_lo_reg < 16'h05DC
      |-> ##[0:6] rate == 2'h0) else $error("fast pulse not adopted");
endmodule : serial_port_checker
bind printer_serial_port serial_port_checker #(.ADDR_W(ADDR_W)) chk (.clk(clk), .rst_b(rst_b),
  .ce(ce), .rx_pin(rx_pin), .tx_pin(tx_pin), .print_all(print_all), .print_key(print_key),
  .key_is_print(key_is_print), .rec_count(rec_count), .busy(busy), .rate(rate));
`default_nettype wire

// ### serial_printer_model.sv
// Behavioural serial printer on the far side of the port
`timescale 1ns/100ps
`default_nettype none
module serial_printer_model (
  input wire logic clk, // Bench clock
  input wire logic tx_pin, // Line from the port
  input wire logic [15:0] div, // Cycles per bit
  output logic rx_pin // Line back to the port
);
  logic [8:0] got[$];
  logic [7:0] shift;
  // Line idles at mark; no handshake line exists to hold the port off
  initial rx_pin = 1'b1;
  // Sample mid-bit, LSB first, then flag a missing stop bit in bit 8
  always begin
    @(negedge tx_pin);
    repeat (div / 2) @(posedge clk);
    if (!tx_pin) begin
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge clk);
        shift[i] = tx_pin;
      end
      repeat (div) @(posedge clk);
      got.push_back({!tx_pin, shift});
    end
  end
  // A low pulse of n cycles lets the port measure the rate
  task automatic send_pulse(input int n);
    @(posedge clk);
    rx_pin <= 1'b0;
    repeat (n) @(posedge clk);
    rx_pin <= 1'b1;
  endtask : send_pulse
endmodule : serial_printer_model
`default_nettype wire

// ### printer_serial_port_tb.sv
// Self-checking bench for the printer serial port
`timescale 1ns/100ps
`default_nettype none
module printer_serial_port_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rx_pin, tx_pin, print_all, print_key, key_is_print, busy;
  logic [3:0] rec_count, mem_addr;
  logic [7:0] live_value, seed;
  logic [7:0] mem_data = 8'h00;
  logic [7:0] mem [16];
  logic [1:0] rate;
  logic [15:0] line_div = 16'(serial_print_pkg::DIV_HI);
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int widths [4] = '{4166, 2083, 1041, 4166};
  logic [1:0] codes [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
  printer_serial_port #(.ADDR_W(4), .REC_BYTES(1)) uut (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .print_all(print_all), .print_key(print_key),
    .key_is_print(key_is_print), .rec_count(rec_count), .mem_addr(mem_addr),
    .mem_data(mem_data), .live_value(live_value), .busy(busy), .rate(rate));
  serial_printer_model printer (.clk(clk), .tx_pin(tx_pin), .div(line_div),
    .rx_pin(rx_pin));
  always #12.5 clk = ~clk;
  // Record memory with one cycle of read latency
  always @(posedge clk) mem_data <= mem[mem_addr];
  // Hang guard: five characters at two rates and the rate pulses need about 85000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 96000) begin
      fails++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // A good frame carries the byte with no stop-bit flag
  function automatic logic [8:0] frame_of(input logic [7:0] d);
    return {1'b0, d};
  endfunction : frame_of
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic pulse_req(input logic all, input logic key);
    @(negedge clk);
    print_all = all;
    print_key = key;
    @(negedge clk);
    print_all = 1'b0;
    print_key = 1'b0;
  endtask : pulse_req
  task automatic wait_chars(input int n);
    while (printer.got.size() < n) @(negedge clk);
  endtask : wait_chars
  // Key print of a fresh random reading; n is its place in the printer's queue
  task automatic print_live(input int n);
    seed = lfsr(seed);
    live_value = seed;
    key_is_print = 1'b1;
    pulse_req(1'b0, 1'b1);
    check("busy", {8'h00, busy}, 9'h001);
    wait_chars(n + 1);
    check("live char", printer.got[n], frame_of(live_value));
  endtask : print_live
  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    {print_all, print_key, key_is_print} = 3'h0;
    rec_count = 4'h0;
    seed = 8'h16;
    foreach (mem[i]) begin
      seed = lfsr(seed);
      mem[i] = seed;
    end
    mem[0] = 8'h00;
    mem[1] = 8'hFF;
    seed = lfsr(seed);
    live_value = seed;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    check("rate", {7'h00, rate}, 9'h000);
    check("tx", {8'h00, tx_pin}, 9'h001);
    $display("test reset done");
    // Slow, then faster, then a slow pulse that must not undo the fast rate
    for (int i = 0; i < 4; i++) begin
      printer.send_pulse(widths[i]);
      repeat (10) @(negedge clk);
      check("rate", {7'h00, rate}, {7'h00, codes[i]});
      // One key print at the middle rate before the line speeds up
      if (i == 1) begin
        line_div = 16'(serial_print_pkg::DIV_MID);
        print_live(0);
        key_is_print = 1'b0;
        line_div = 16'(serial_print_pkg::DIV_HI);
      end
    end
    $display("test rate done");
    // Store-configured key and an empty memory both leave the port idle
    for (int i = 0; i < 2; i++) begin
      pulse_req(i[0], !i[0]);
      check("busy", {8'h00, busy}, 9'h000);
    end
    $display("test refuse done");
    print_live(1);
    $display("test live done");
    // Both requests in one cycle: the memory dump wins
    rec_count = 4'h3;
    pulse_req(1'b1, 1'b1);
    check("busy", {8'h00, busy}, 9'h001);
    wait_chars(5);
    for (int i = 0; i < 3; i++) check("record", printer.got[i + 2], frame_of(mem[i]));
    repeat (12000) @(negedge clk);
    check("chars", 9'(printer.got.size()), 9'h005);
    check("addr", {5'h00, mem_addr}, 9'h000);
    $display("test records done");
    report_and_stop();
  end
endmodule : printer_serial_port_tb
`default_nettype wire
